// file: core/blk_lock_pkg.sv
// constants and carrier types for the serial flash block-lock controller
// assumes one system clock; serial pins are asynchronous to it
package blk_lock_pkg;
   // command opcodes
   localparam logic [7:0] OP_WR_ENABLE = 8'h06;
   localparam logic [7:0] OP_WR_DISABLE = 8'h04;
   localparam logic [7:0] OP_RD_LOCK_A = 8'h3c;
   localparam logic [7:0] OP_RD_LOCK_B = 8'h3d;
   localparam logic [7:0] OP_GLOBAL_LOCK = 8'h7e;
   localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
   localparam logic [7:0] OP_BLOCK_LOCK = 8'h36;
   localparam logic [7:0] OP_BLOCK_UNLOCK = 8'h39;
   // serial framing
   localparam int BITS_PER_BYTE = 8;
   localparam logic [2:0] OPCODE_BYTES = 3'h1;
   localparam logic [2:0] OPC_ADDR_BYTES = 3'h4;
   // lock array: 4KB blocks inside a 512KB array
   localparam int NUM_BLOCKS = 128;
   localparam int BLK_IDX_W = 7;
   localparam int BLK_LSB = 12;
   localparam int GRAN_BLOCKS = 16;
   localparam logic [NUM_BLOCKS-1:0] LOCK_RESET = {NUM_BLOCKS{1'b1}};
   localparam logic WEL_RESET = 1'b0;
   // security registers: 4 x 128 bytes, bits 8:7 register, 6:0 byte
   localparam int SEC_REGS = 4;
   localparam int SEC_BYTES = 128;
   localparam int SEC_SEL_LSB = 7;
   localparam int SEC_ADDR_W = 9;
   localparam logic [7:0] SEC_ERASED = 8'hff;
   localparam logic [1:0] SEC_FACTORY_REG = 2'h0;
   localparam logic [7:0] RD_LOCK_UPPER = 8'h00;

   // legacy protection fields used when per-block scheme is off
   typedef struct packed {
      logic complement;
      logic granularity;
      logic top_bottom;
      logic [2:0] extent;
   } protect_cfg_t;

   // serial receive phases, gray along opcode, address, data
   typedef enum logic [1:0] {
      PH_OPCODE = 2'b00,
      PH_ADDR = 2'b01,
      PH_DATA = 2'b11,
      PH_IGNORE = 2'b10
   } phase_t;
endpackage

// file: core/otp_sec_store.sv
// four one-time-programmable security registers, kept apart from the array
// assumes writes come from same-clock logic; storage is not reset
`timescale 1ns/10ps
`default_nettype none
module otp_sec_store (
   input wire logic clk,
   input wire logic wr_en,
   input wire logic factory_en,
   input wire logic [blk_lock_pkg::SEC_ADDR_W-1:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata_q
);
   // cells start erased (all ones) and keep their contents across reset
   logic [7:0] mem_q [blk_lock_pkg::SEC_REGS*blk_lock_pkg::SEC_BYTES] =
      '{default: blk_lock_pkg::SEC_ERASED};
   logic [1:0] reg_sel;
   logic wr_ok;

   // bits 8:7 pick the register, 6:0 the byte; register 0 is factory only
   assign reg_sel =
      addr[blk_lock_pkg::SEC_ADDR_W-1:blk_lock_pkg::SEC_SEL_LSB];
   assign wr_ok = wr_en &&
      (factory_en || reg_sel != blk_lock_pkg::SEC_FACTORY_REG);

   // programming only clears bits, as in real otp cells
   always_ff @(posedge clk)
   begin
      if (wr_ok)
      begin
         mem_q[addr] <= mem_q[addr] & wdata;
      end
      rdata_q <= mem_q[addr];
   end
endmodule
`default_nettype wire

// file: core/blk_lock_ctrl.sv
// serial flash block-lock command decoder, lock array and protection check
// assumes spi mode 0 pins asynchronous to MCLK, SCK at most MCLK/8
//
// Overview of operation
// - chip select released mid-byte abandons the command, nothing changes
// - every block lock bit is one after reset
// - both read-lock opcodes behave identically
// - block locks apply only with scheme select set, else legacy fields
// - read-lock takes three address bytes, msb first, 24 clocks
// - answer byte msb first, bit 0 is lock, upper bits zero
// - answer byte repeats while chip select stays low
// - reported lock is that of the 4KB region holding the address
// - program or erase to a locked block is refused
// - opcodes arrive over eight clocks, msb first
// - global lock sets all locks and clears write enable at end
// - global unlock clears all locks and write enable at end
// - four 128-byte security registers separate from the array
// - security bytes 0-127 factory, 128-511 user registers
// - block unlock clears the addressed lock and write enable at end
// - security address uses bits 8:0, 8:7 register, 6:0 byte
`timescale 1ns/10ps
`default_nettype none
module blk_lock_ctrl (
   input wire logic MCLK,
   input wire logic SYS_RST,
   input wire logic CS_N,
   input wire logic SCK,
   input wire logic SI,
   output logic SO,
   output logic SO_OE_N,
   input wire logic PROTECT_SCHEME_SELECT,
   input wire blk_lock_pkg::protect_cfg_t PROTECT_CFG,
   input wire logic PE_REQ,
   input wire logic [23:0] PE_ADDR,
   output logic PE_ALLOW_Q,
   output logic PE_REFUSE_Q,
   output logic WRITE_ENABLE_LATCH,
   input wire logic SEC_WR,
   input wire logic SEC_FACTORY_EN,
   input wire logic [23:0] SEC_ADDR,
   input wire logic [7:0] SEC_WDATA,
   output logic [7:0] SEC_RDATA
);
   localparam int BW = blk_lock_pkg::BLK_IDX_W;

   logic [2:0] s1_q, s2_q, s3_q;
   logic cs_n_s, sck_s, si_s, sck_rise, sck_fall, cs_rise;
   blk_lock_pkg::phase_t phase_q;
   logic [2:0] bit_cnt_q, byte_cnt_q, out_idx_q;
   logic [7:0] opcode_q, shift_q;
   logic [23:0] addr_q;
   logic [blk_lock_pkg::NUM_BLOCKS-1:0] lock_q;
   logic wel_q, rd_lock_bit_q, so_q, oe_n_q;
   logic [7:0] rd_byte;
   logic byte_done, aligned, is_rd_lock, pe_protected;
   logic [BW-1:0] addr_blk, pe_blk;

   // two-stage synchronisers for chip select, clock and data
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         s1_q <= 3'h5; // idle levels: deselected, clock low
         s2_q <= 3'h5;
         s3_q <= 3'h5;
      end
      else
      begin
         s1_q <= {CS_N, SCK, SI};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // edges seen on the second and third stages only
   assign cs_n_s = s2_q[2];
   assign sck_s = s2_q[1];
   assign si_s = s2_q[0];
   assign sck_rise = !cs_n_s && sck_s && !s3_q[1];
   assign sck_fall = !cs_n_s && !sck_s && s3_q[1];
   assign cs_rise = cs_n_s && !s3_q[2];
   assign byte_done = sck_rise && bit_cnt_q == 3'h7;
   assign aligned = bit_cnt_q == 3'h0;
   assign is_rd_lock = opcode_q == blk_lock_pkg::OP_RD_LOCK_A ||
                       opcode_q == blk_lock_pkg::OP_RD_LOCK_B;
   // 4KB region index from address bits 18:12
   assign addr_blk = addr_q[blk_lock_pkg::BLK_LSB +: BW];
   assign pe_blk = PE_ADDR[blk_lock_pkg::BLK_LSB +: BW];

   // bit and byte counters, msb-first shift register
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST || cs_n_s)
      begin
         bit_cnt_q <= 3'h0;
         byte_cnt_q <= 3'h0;
         shift_q <= 8'h00;
      end
      else if (sck_rise)
      begin
         bit_cnt_q <= bit_cnt_q + 3'h1;
         shift_q <= {shift_q[6:0], si_s};
         if (bit_cnt_q == 3'h7 && byte_cnt_q != 3'h7)
         begin
            byte_cnt_q <= byte_cnt_q + 3'h1;
         end
      end
   end

   // opcode, address capture and phase tracking
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST || cs_n_s)
      begin
         phase_q <= blk_lock_pkg::PH_OPCODE;
         opcode_q <= 8'h00;
         addr_q <= 24'h000000;
      end
      else if (byte_done)
      begin
         case (phase_q)
            blk_lock_pkg::PH_OPCODE:
            begin
               opcode_q <= {shift_q[6:0], si_s};
               phase_q <= blk_lock_pkg::PH_ADDR;
            end
            blk_lock_pkg::PH_ADDR:
            begin
               addr_q <= {addr_q[15:0], shift_q[6:0], si_s};
               if (byte_cnt_q == blk_lock_pkg::OPC_ADDR_BYTES - 3'h1)
               begin
                  phase_q <= is_rd_lock ? blk_lock_pkg::PH_DATA
                                        : blk_lock_pkg::PH_IGNORE;
               end
            end
            blk_lock_pkg::PH_DATA: phase_q <= blk_lock_pkg::PH_DATA;
            default: phase_q <= blk_lock_pkg::PH_IGNORE;
         endcase
      end
   end

   // read-lock answer: bit 0 is the lock, repeated while selected
   assign rd_byte = {blk_lock_pkg::RD_LOCK_UPPER[7:1], rd_lock_bit_q};
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST || cs_n_s)
      begin
         out_idx_q <= 3'h0;
         so_q <= 1'b0;
         oe_n_q <= 1'b1;
         rd_lock_bit_q <= 1'b0;
      end
      else
      begin
         // sample until the first answer bit, so the last address byte counts
         if (oe_n_q)
         begin
            rd_lock_bit_q <= lock_q[addr_blk];
         end
         if (phase_q == blk_lock_pkg::PH_DATA && sck_fall)
         begin
            so_q <= rd_byte[3'h7 - out_idx_q];
            oe_n_q <= 1'b0;
            out_idx_q <= out_idx_q + 3'h1;
         end
      end
   end

   // lock array and write enable latch, updated when chip select rises
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         lock_q <= blk_lock_pkg::LOCK_RESET;
         wel_q <= blk_lock_pkg::WEL_RESET;
      end
      else if (cs_rise && aligned)
      begin
         case (opcode_q)
            blk_lock_pkg::OP_WR_ENABLE:
               if (byte_cnt_q >= blk_lock_pkg::OPCODE_BYTES)
               begin
                  wel_q <= 1'b1;
               end
            blk_lock_pkg::OP_WR_DISABLE:
               if (byte_cnt_q >= blk_lock_pkg::OPCODE_BYTES)
               begin
                  wel_q <= 1'b0;
               end
            blk_lock_pkg::OP_GLOBAL_LOCK:
               if (wel_q && byte_cnt_q >= blk_lock_pkg::OPCODE_BYTES)
               begin
                  lock_q <= {blk_lock_pkg::NUM_BLOCKS{1'b1}};
                  wel_q <= 1'b0;
               end
            blk_lock_pkg::OP_GLOBAL_UNLOCK:
               if (wel_q && byte_cnt_q >= blk_lock_pkg::OPCODE_BYTES)
               begin
                  lock_q <= {blk_lock_pkg::NUM_BLOCKS{1'b0}};
                  wel_q <= 1'b0;
               end
            blk_lock_pkg::OP_BLOCK_UNLOCK:
               if (wel_q && byte_cnt_q >= blk_lock_pkg::OPC_ADDR_BYTES)
               begin
                  lock_q[addr_blk] <= 1'b0;
                  wel_q <= 1'b0;
               end
            blk_lock_pkg::OP_BLOCK_LOCK:
               if (wel_q && byte_cnt_q >= blk_lock_pkg::OPC_ADDR_BYTES)
               begin
                  lock_q[addr_blk] <= 1'b1;
                  wel_q <= 1'b0;
               end
            default: wel_q <= wel_q;
         endcase
      end
   end

   // legacy region check from complement, granularity, top/bottom, extent
   function automatic logic legacy_hit(input logic [BW-1:0] blk,
                                       input blk_lock_pkg::protect_cfg_t c);
      int span;
      logic hit;
      span = 0;
      hit = 1'b0;
      if (c.extent == 3'h7)
      begin
         span = blk_lock_pkg::NUM_BLOCKS;
      end
      else if (c.extent != 3'h0)
      begin
         span = (c.granularity ? 1 : blk_lock_pkg::GRAN_BLOCKS)
                << (int'(c.extent) - 1);
      end
      if (c.top_bottom)
      begin
         hit = int'(blk) >= blk_lock_pkg::NUM_BLOCKS - span;
      end
      else
      begin
         hit = int'(blk) < span;
      end
      return hit ^ c.complement;
   endfunction

   assign pe_protected = PROTECT_SCHEME_SELECT ? lock_q[pe_blk]
                         : legacy_hit(pe_blk, PROTECT_CFG);

   // program/erase gate, one-cycle answer per request
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         PE_ALLOW_Q <= 1'b0;
         PE_REFUSE_Q <= 1'b0;
      end
      else
      begin
         PE_ALLOW_Q <= PE_REQ && !pe_protected;
         PE_REFUSE_Q <= PE_REQ && pe_protected;
      end
   end

   // security register store
   otp_sec_store u_sec (
      .clk(MCLK),
      .wr_en(SEC_WR),
      .factory_en(SEC_FACTORY_EN),
      .addr(SEC_ADDR[blk_lock_pkg::SEC_ADDR_W-1:0]),
      .wdata(SEC_WDATA),
      .rdata_q(SEC_RDATA)
   );

   // pin and status outputs straight from flip-flops
   assign SO = so_q;
   assign SO_OE_N = oe_n_q;
   assign WRITE_ENABLE_LATCH = wel_q;

   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (SYS_RST);

   sequence s_glock_end;
      cs_rise && aligned && wel_q && opcode_q == blk_lock_pkg::OP_GLOBAL_LOCK
         && byte_cnt_q != 3'h0;
   endsequence
   sequence s_gunlock_end;
      cs_rise && aligned && wel_q
         && opcode_q == blk_lock_pkg::OP_GLOBAL_UNLOCK && byte_cnt_q != 3'h0;
   endsequence

   a_reset_all_locked: assert property (disable iff (1'b0)
      SYS_RST |=> &lock_q && !wel_q)
      else $error("locks not set by reset");
   a_global_lock_set: assert property (s_glock_end
      |=> &lock_q && !wel_q)
      else $error("global lock did not set all");
   a_global_unlock_clr: assert property (s_gunlock_end
      |=> lock_q == '0 && !wel_q)
      else $error("global unlock did not clear all");
   a_midbyte_abort: assert property (cs_rise && !aligned
      |=> $stable(lock_q) && $stable(wel_q))
      else $error("mid-byte end acted");
   a_no_wel_ignore: assert property (cs_rise && !wel_q
      |=> $stable(lock_q))
      else $error("lock changed without write enable");
   a_pe_refuse_lock: assert property (PE_REQ && PROTECT_SCHEME_SELECT
      && lock_q[pe_blk] |=> PE_REFUSE_Q && !PE_ALLOW_Q)
      else $error("locked block not refused");
   a_block_unlock_one: assert property (cs_rise && aligned && wel_q
      && opcode_q == blk_lock_pkg::OP_BLOCK_UNLOCK
      && byte_cnt_q >= blk_lock_pkg::OPC_ADDR_BYTES
      |=> !lock_q[$past(addr_blk)] && !wel_q)
      else $error("block unlock failed");
   a_answer_lsb_lock: assert property (sck_fall && out_idx_q == 3'h7
      && phase_q == blk_lock_pkg::PH_DATA |=> so_q == lock_q[addr_blk])
      else $error("answer bit 0 not lock");
   a_answer_repeats: assert property (sck_fall && out_idx_q == 3'h7
      && phase_q == blk_lock_pkg::PH_DATA |=> out_idx_q == 3'h0 && !oe_n_q)
      else $error("answer did not wrap");
endmodule
`default_nettype wire

// file: tb/host_spi_model.sv
// host spi controller model: mode 0 frames, msb first
// assumes MCLK runs; serial clock kept well under MCLK/8
`timescale 1ns/10ps
`default_nettype none
module host_spi_model (
   input wire logic MCLK,
   input wire logic SO,
   input wire logic SO_OE_N,
   output logic CS_N,
   output logic SCK,
   output logic SI
);
   int half = 6;
   // idle: deselected, clock low
   initial
   begin
      CS_N = 1'b1;
      SCK = 1'b0;
      SI = 1'b0;
   end
   // one serial clock carrying bit b, changed while clock is low
   task automatic pulse(input logic b);
      SI = b;
      repeat (half) @(negedge MCLK);
      SCK = 1'b1;
      repeat (half) @(negedge MCLK);
      SCK = 1'b0;
   endtask
   // opcode, nab address bits, nrd answer bits; undriven SO reads as x
   task automatic frame(input logic [7:0] op, input logic [23:0] addr,
      input int nab, input int nrd, output logic [15:0] rd);
      int i;
      rd = '0;
      @(negedge MCLK);
      CS_N = 1'b0;
      for (i = 7; i >= 0; i--) pulse(op[i]);
      for (i = 23; i >= 24 - nab; i--) pulse(addr[i]);
      for (i = 0; i < nrd; i++)
      begin
         repeat (half) @(negedge MCLK);
         rd = {rd[14:0], SO_OE_N ? 1'bx : SO};
         SCK = 1'b1;
         repeat (half) @(negedge MCLK);
         SCK = 1'b0;
      end
      repeat (half) @(negedge MCLK);
      CS_N = 1'b1;
      SI = ~SI; // released line does not hold its last value
      repeat (8) @(negedge MCLK);
   endtask
endmodule
`default_nettype wire

// file: tb/test_blk_lock_ctrl.sv
// self-checking bench for the block-lock controller
// assumes host_spi_model drives the serial pins; one 40 MHz clock
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) \
   begin \
      total_checks++; \
      if ((s) !== (e)) \
      begin \
         fails++; \
         $display("MISMATCH %s exp %h seen %h", n, e, s); \
      end \
   end
module test_blk_lock_ctrl;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   wire logic cs_n, sck, si;
   logic so, so_oe_n, scheme, pe_req, pe_allow_q, pe_refuse_q, write_enable_latch;
   logic sec_wr, sec_fac;
   logic [23:0] pe_addr, sec_addr;
   logic [7:0] sec_wdata, sec_rdata;
   logic [15:0] rd;
   blk_lock_pkg::protect_cfg_t cfg;
   int fails = 0;
   int total_checks = 0;
   always #12.5 mclk = ~mclk;
   blk_lock_ctrl dut (.MCLK(mclk), .SYS_RST(sys_rst), .CS_N(cs_n),
      .SCK(sck), .SI(si), .SO(so), .SO_OE_N(so_oe_n),
      .PROTECT_SCHEME_SELECT(scheme), .PROTECT_CFG(cfg), .PE_REQ(pe_req),
      .PE_ADDR(pe_addr), .PE_ALLOW_Q(pe_allow_q),
      .PE_REFUSE_Q(pe_refuse_q), .WRITE_ENABLE_LATCH(write_enable_latch),
      .SEC_WR(sec_wr), .SEC_FACTORY_EN(sec_fac), .SEC_ADDR(sec_addr),
      .SEC_WDATA(sec_wdata), .SEC_RDATA(sec_rdata));
   host_spi_model host (.MCLK(mclk), .SO(so), .SO_OE_N(so_oe_n),
      .CS_N(cs_n), .SCK(sck), .SI(si));
   // verdict and end of run
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // command with no address, then check the latch
   task automatic cmd(input logic [7:0] op, input logic exp_wel);
      host.frame(op, 24'h0, 0, 0, rd);
      `CHK("wel", exp_wel, write_enable_latch)
   endtask
   // command frame with nab address bits and no answer
   task automatic fr(input logic [7:0] op, input logic [23:0] a,
      input int nab);
      host.frame(op, a, nab, 0, rd);
   endtask
   // read-lock query, two answer bytes
   task automatic rl(input logic [7:0] op, input logic [23:0] a,
      input logic lk);
      host.frame(op, a, 24, 16, rd);
      `CHK("lockbyte", {7'h0, lk, 7'h0, lk}, rd)
   endtask
   // program/erase gate
   task automatic pe(input logic [23:0] a, input logic ok);
      @(negedge mclk);
      pe_req = 1'b1;
      pe_addr = a;
      @(negedge mclk);
      pe_req = 1'b0;
      `CHK("allow", ok, pe_allow_q)
      `CHK("refuse", ~ok, pe_refuse_q)
   endtask
   // security byte write then read back at a second address, an alias or the same one
   task automatic sec(input logic [23:0] wa, input logic [23:0] ra,
      input logic [7:0] d, input logic [7:0] e);
      @(negedge mclk);
      sec_wr = 1'b1;
      sec_addr = wa;
      sec_wdata = d;
      @(negedge mclk);
      sec_wr = 1'b0;
      sec_addr = ra;
      repeat (2) @(negedge mclk);
      `CHK("secbyte", e, sec_rdata)
   endtask
   // watchdog
   initial
   begin
      repeat (40000) @(posedge mclk);
      fails++;
      conclude();
   end
   // main sequence
   initial
   begin
      scheme = 1'b1;
      cfg = '0;
      pe_req = 1'b0;
      pe_addr = '0;
      sec_wr = 1'b0;
      sec_fac = 1'b0;
      sec_addr = '0;
      sec_wdata = '0;
      repeat (20) @(negedge mclk);
      sys_rst = 1'b0;
      repeat (4) @(negedge mclk);
      `CHK("wel", 1'b0, write_enable_latch)
      pe(24'h001234, 1'b0);
      rl(blk_lock_pkg::OP_RD_LOCK_A, 24'h001234, 1'b1);
      cmd(blk_lock_pkg::OP_GLOBAL_UNLOCK, 1'b0);
      rl(blk_lock_pkg::OP_RD_LOCK_B, 24'h07f000, 1'b1);
      cmd(blk_lock_pkg::OP_WR_ENABLE, 1'b1);
      fr(blk_lock_pkg::OP_GLOBAL_UNLOCK, 24'hf00000, 4);
      `CHK("wel", 1'b1, write_enable_latch)
      rl(blk_lock_pkg::OP_RD_LOCK_A, 24'h000000, 1'b1);
      cmd(blk_lock_pkg::OP_GLOBAL_UNLOCK, 1'b0);
      rl(blk_lock_pkg::OP_RD_LOCK_B, 24'h001234, 1'b0);
      pe(24'h001234, 1'b1);
      cmd(blk_lock_pkg::OP_WR_ENABLE, 1'b1);
      cmd(blk_lock_pkg::OP_GLOBAL_LOCK, 1'b0);
      rl(blk_lock_pkg::OP_RD_LOCK_A, 24'h05a000, 1'b1);
      cmd(blk_lock_pkg::OP_WR_ENABLE, 1'b1);
      fr(blk_lock_pkg::OP_BLOCK_UNLOCK, 24'h001234, 24);
      `CHK("wel", 1'b0, write_enable_latch)
      rl(blk_lock_pkg::OP_RD_LOCK_A, 24'h001fff, 1'b0);
      rl(blk_lock_pkg::OP_RD_LOCK_B, 24'h002000, 1'b1);
      pe(24'h001000, 1'b1);
      pe(24'h000fff, 1'b0);
      cmd(blk_lock_pkg::OP_WR_ENABLE, 1'b1);
      fr(blk_lock_pkg::OP_BLOCK_UNLOCK, 24'h002000, 16);
      `CHK("wel", 1'b1, write_enable_latch)
      rl(blk_lock_pkg::OP_RD_LOCK_B, 24'h002000, 1'b1);
      fr(blk_lock_pkg::OP_BLOCK_LOCK, 24'h001800, 24);
      `CHK("wel", 1'b0, write_enable_latch)
      rl(blk_lock_pkg::OP_RD_LOCK_A, 24'h001000, 1'b1);
      cmd(blk_lock_pkg::OP_WR_ENABLE, 1'b1);
      cmd(blk_lock_pkg::OP_WR_DISABLE, 1'b0);
      fr(blk_lock_pkg::OP_BLOCK_UNLOCK, 24'h001000, 24);
      rl(blk_lock_pkg::OP_RD_LOCK_B, 24'h001000, 1'b1);
      cmd(blk_lock_pkg::OP_WR_ENABLE, 1'b1);
      cmd(blk_lock_pkg::OP_GLOBAL_UNLOCK, 1'b0);
      cmd(blk_lock_pkg::OP_WR_ENABLE, 1'b1);
      // reset in mid-run must lock everything again
      sys_rst = 1'b1;
      repeat (2) @(negedge mclk);
      sys_rst = 1'b0;
      repeat (4) @(negedge mclk);
      `CHK("wel", 1'b0, write_enable_latch)
      rl(blk_lock_pkg::OP_RD_LOCK_B, 24'h03c000, 1'b1);
      scheme = 1'b0;
      pe(24'h000000, 1'b1);
      cfg.extent = 3'h7;
      pe(24'h001000, 1'b0);
      // two blocks at the top, then inverted
      cfg.granularity = 1'b1;
      cfg.top_bottom = 1'b1;
      cfg.extent = 3'h2;
      pe(24'h07e000, 1'b0);
      pe(24'h07d000, 1'b1);
      cfg.complement = 1'b1;
      pe(24'h07d000, 1'b0);
      // sixteen blocks at the bottom
      cfg = '0;
      cfg.extent = 3'h1;
      pe(24'h00f000, 1'b0);
      pe(24'h010000, 1'b1);
      cmd(blk_lock_pkg::OP_WR_ENABLE, 1'b1);
      sec(24'hfe0005, 24'h000005, 8'h00, 8'hff);
      sec(24'habc185, 24'h000185, 8'h5a, 8'h5a);
      sec(24'h000080, 24'h7ff080, 8'h0f, 8'h0f);
      sec(24'h000100, 24'h000100, 8'hff, 8'hff);
      conclude();
   end
endmodule
`default_nettype wire
